// ### verilog/rail_sequencer.sv
`timescale 1ns/1ns
// Behaviour
// R1 - eighth code: sources, positive gate, negative+common
// R2 - gaps from three fields; zero fastest
// R3 - power-off unmonitored, each step by gaps
// R4 - zero gaps still give 1 ms off-steps
// R5 - burn command stores sequence settings
// R6 - core regulator off 200 ms later
// R7 - 9-bit setpoint split over two registers
// R8 - code zero -2.49 V, 6.83 mV steps
// R9 - deviation over 0.25 V sets fault flag
// R10 - long current limit disables all rails
// R11 - out-of-range setpoint write is NACKed, ignored (code: only while DLY_COMP_EN is clear)
// R12 - sensor-select one picks internal sensor
// R13 - internal sensor feeds converter directly
// R14 - converter result in temperature register
// R15 - correction samples once per second
// R16 - uncorrected setpoint until first sample
// R17 - full setpoint is 25-degree reference
// R18 - low lowers, high raises, at thresholds
// R19 - second high offset adds above first
// R20 - sequence select in low-point register
// R21 - host burns by writing address 0x78
// R22 - interpolate, saturate, clamp to 9 bits
// R23 - setpoint applies at accepted byte end
module rail_sequencer #(
   parameter int MS_CYCLES = rail_seq_pkg::MS_CYC,
   parameter int CORE_CYCLES = rail_seq_pkg::CORE_OFF_CYC,
   parameter int SAMPLE_CYCLES = rail_seq_pkg::SAMPLE_CYC
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic scl,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic enable_pin,
   input wire logic vcom_deviation,
   input wire logic vcom_ilimit,
   output rail_seq_pkg::rail_en_type rails,
   output logic core_regulator_en,
   output logic [8:0] vcom_code,
   output logic adc_internal_sel,
   output logic adc_start,
   input wire logic adc_done,
   input wire logic [7:0] adc_result,
   output logic nv_burn,
   output logic [7:0] nv_seq_data
);
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [4:0] group_of(input logic [2:0] seq, input logic [1:0] k);
      logic [19:0] row;
      row = rail_seq_pkg::SEQ_TABLE[seq];
      return row[k*5 +: 5];
   endfunction : group_of
   function automatic logic [1:0] last_of(input logic [2:0] seq);
      return (seq >= 3'h6) ? 2'd2 : 2'd3;
   endfunction : last_of

   // ----------------------------------------
   // input synchronisers
   // ----------------------------------------
   logic [4:0] sync1_r, sync2_r;
   logic scl_d_r, sda_d_r;
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         sync1_r <= 5'h1_f;
         sync2_r <= 5'h1_f;
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
      end else begin
         sync1_r <= {scl, sda_in, enable_pin, vcom_deviation, vcom_ilimit};
         sync2_r <= sync1_r;
         scl_d_r <= sync2_r[4];
         sda_d_r <= sync2_r[3];
      end
   end
   wire scl_s = sync2_r[4];
   wire sda_s = sync2_r[3];
   wire en_s = sync2_r[2];
   wire dev_s = sync2_r[1];
   wire ilim_s = sync2_r[0];
   wire scl_rise = scl_s & ~scl_d_r;
   wire scl_fall = ~scl_s & scl_d_r;
   wire start_c = scl_s & scl_d_r & sda_d_r & ~sda_s;
   wire stop_c = scl_s & scl_d_r & ~sda_d_r & sda_s;

   // ----------------------------------------
   // registers and serial slave
   // ----------------------------------------
   logic [7:0] setpoint_r, delay_r, low_r, high_r, extra_r, lthr_r, hthr_r, min_r, max_r, cfg_r;
   logic [7:0] temp_r, ptr_r, shift_r, tx_r;
   logic fault_r, ack_r, mnack_r, burn_r;
   logic [3:0] bit_r;
   rail_seq_pkg::ser_phase_type phase_r;
   rail_seq_pkg::seq_state_type state_r;
   rail_seq_pkg::rail_en_type rails_r;
   wire comp_en = delay_r[rail_seq_pkg::DLY_COMP_EN];
   wire [2:0] seq_sel = low_r[rail_seq_pkg::LOW_SEQ +: 3];
   wire [8:0] base = {setpoint_r, delay_r[rail_seq_pkg::DLY_SP_LSB]}; // [R7] [R17]
   wire byte_done = scl_fall && bit_r == 4'd7;
   wire [7:0] rx = shift_r;
   wire sp_wr = byte_done && phase_r == rail_seq_pkg::PH_WR && ptr_r == rail_seq_pkg::ADDR_SETPOINT;
   wire sp_bad = !comp_en && (rx < min_r || rx > max_r);
   wire nack_evt = sp_wr && sp_bad; // [R11]
   wire wr_ok = byte_done && phase_r == rail_seq_pkg::PH_WR && !nack_evt;
   wire addr_hit = rx[7:1] == rail_seq_pkg::SLAVE_ADDR;
   wire clr_fault = wr_ok && ptr_r == rail_seq_pkg::ADDR_SECOND_FAULT_REG && rx[rail_seq_pkg::FLT2_VCOM];
   logic fault_set;
   logic [7:0] rd_data;
   always_comb begin
      case (ptr_r)
         rail_seq_pkg::ADDR_TEMP: rd_data = temp_r;
         rail_seq_pkg::ADDR_SETPOINT: rd_data = setpoint_r;
         rail_seq_pkg::ADDR_DELAY: rd_data = delay_r;
         rail_seq_pkg::ADDR_LOW_POINT: rd_data = low_r;
         rail_seq_pkg::ADDR_HIGH_POINT: rd_data = high_r;
         rail_seq_pkg::ADDR_EXTRA_HIGH: rd_data = extra_r;
         rail_seq_pkg::ADDR_LOW_THR: rd_data = lthr_r;
         rail_seq_pkg::ADDR_HIGH_THR: rd_data = hthr_r;
         rail_seq_pkg::ADDR_MIN: rd_data = min_r;
         rail_seq_pkg::ADDR_MAX: rd_data = max_r;
         rail_seq_pkg::ADDR_CONFIG: rd_data = cfg_r;
         rail_seq_pkg::ADDR_SECOND_FAULT_REG: rd_data = {7'h00, fault_r};
         rail_seq_pkg::ADDR_STATUS: rd_data = {state_r, rails_r};
         default: rd_data = 8'h00;
      endcase
   end
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         phase_r <= rail_seq_pkg::PH_IDLE;
         bit_r <= 4'h0;
         shift_r <= 8'h00;
         tx_r <= 8'hff;
         ack_r <= 1'b0;
         mnack_r <= 1'b0;
         ptr_r <= 8'h00;
      end else if (start_c) begin
         phase_r <= rail_seq_pkg::PH_ADDR;
         // the scl fall that closes the start wraps this to zero
         bit_r <= 4'hf;
         ack_r <= 1'b0;
      end else if (stop_c) begin
         phase_r <= rail_seq_pkg::PH_IDLE;
         ack_r <= 1'b0;
      end else begin
         if (scl_rise && bit_r < 4'd8) shift_r <= {shift_r[6:0], sda_s};
         if (scl_rise && bit_r == 4'd8) mnack_r <= sda_s;
         if (byte_done) begin
            bit_r <= 4'd8;
            ack_r <= 1'b0;
            case (phase_r)
               rail_seq_pkg::PH_ADDR: begin
                  ack_r <= addr_hit;
                  phase_r <= !addr_hit ? rail_seq_pkg::PH_IDLE :
                     (rx[0] ? rail_seq_pkg::PH_RD : rail_seq_pkg::PH_REG);
               end
               rail_seq_pkg::PH_REG: begin
                  ack_r <= 1'b1;
                  ptr_r <= rx;
                  phase_r <= rail_seq_pkg::PH_WR;
               end
               rail_seq_pkg::PH_WR: begin
                  ack_r <= !nack_evt; // [R11]
                  ptr_r <= ptr_r + 8'h01;
               end
               default: ack_r <= 1'b0;
            endcase
         end else if (scl_fall && bit_r == 4'd8) begin
            ack_r <= 1'b0;
            bit_r <= 4'h0;
            if (phase_r == rail_seq_pkg::PH_RD && !(mnack_r && !ack_r)) begin
               tx_r <= rd_data;
               ptr_r <= ptr_r + 8'h01;
            end else if (phase_r == rail_seq_pkg::PH_RD) begin
               phase_r <= rail_seq_pkg::PH_IDLE;
            end
         end else if (scl_fall && phase_r != rail_seq_pkg::PH_IDLE) begin
            bit_r <= bit_r + 4'h1;
            tx_r <= {tx_r[6:0], 1'b1};
         end
      end
   end
   assign sda_out = 1'b0;
   assign sda_oe = ack_r | (phase_r == rail_seq_pkg::PH_RD && bit_r < 4'd8 && !tx_r[7]);

   // register writes; setpoint takes effect at the end of the accepted byte
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         setpoint_r <= rail_seq_pkg::RST_SETPOINT;
         {delay_r, high_r, extra_r, lthr_r, hthr_r, min_r, cfg_r} <= 56'h0000_0000_0000_00;
         low_r <= rail_seq_pkg::RST_LOW_POINT;
         max_r <= rail_seq_pkg::RST_MAX;
         fault_r <= 1'b0;
         burn_r <= 1'b0;
      end else begin
         burn_r <= wr_ok && ptr_r == rail_seq_pkg::ADDR_BURN; // [R5] [R21]
         fault_r <= fault_set | (fault_r & ~clr_fault); // [R9] [R10]
         if (wr_ok) begin
            case (ptr_r)
               rail_seq_pkg::ADDR_SETPOINT: setpoint_r <= rx; // [R23]
               rail_seq_pkg::ADDR_DELAY: delay_r <= rx;
               rail_seq_pkg::ADDR_LOW_POINT: low_r <= rx; // [R20]
               rail_seq_pkg::ADDR_HIGH_POINT: high_r <= rx;
               rail_seq_pkg::ADDR_EXTRA_HIGH: extra_r <= rx;
               rail_seq_pkg::ADDR_LOW_THR: lthr_r <= rx;
               rail_seq_pkg::ADDR_HIGH_THR: hthr_r <= rx;
               rail_seq_pkg::ADDR_MIN: min_r <= rx;
               rail_seq_pkg::ADDR_MAX: max_r <= rx;
               rail_seq_pkg::ADDR_CONFIG: cfg_r <= rx;
               default: cfg_r <= cfg_r;
            endcase
         end
      end
   end
   assign nv_burn = burn_r;
   assign nv_seq_data = low_r; // [R5]

   // ----------------------------------------
   // rail sequencer
   // ----------------------------------------
   logic [23:0] cnt_r, ilim_cnt_r;
   logic [1:0] step_r;
   logic core_r;
   wire [1:0] last = last_of(seq_sel);
   wire [1:0] gap_next = step_r == 2'd0 ? delay_r[rail_seq_pkg::DLY_GAP1 +: 2] :
      step_r == 2'd1 ? delay_r[rail_seq_pkg::DLY_GAP2 +: 2] : delay_r[rail_seq_pkg::DLY_GAP3 +: 2];
   wire [1:0] gap_here = step_r == 2'd1 ? delay_r[rail_seq_pkg::DLY_GAP1 +: 2] :
      step_r == 2'd2 ? delay_r[rail_seq_pkg::DLY_GAP2 +: 2] : delay_r[rail_seq_pkg::DLY_GAP3 +: 2];
   wire [1:0] gap_off = (gap_here == 2'd0) ? 2'd1 : gap_here; // [R4]
   wire [23:0] ms24 = 24'(MS_CYCLES);
   wire [23:0] tf_cyc = (24'(cfg_r[rail_seq_pkg::CFG_TFAULT +: 2]) + 24'h00_0001) * ms24;
   wire ilim_trip = ilim_s && ilim_cnt_r >= tf_cyc && rails_r != 5'h00;
   assign fault_set = dev_s | ilim_trip;
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) ilim_cnt_r <= 24'h00_0000;
      else ilim_cnt_r <= ilim_s ? ilim_cnt_r + 24'h00_0001 : 24'h00_0000;
   end
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         state_r <= rail_seq_pkg::ST_IDLE;
         rails_r <= 5'h00;
         step_r <= 2'd0;
         cnt_r <= 24'h00_0000;
         core_r <= 1'b1;
      end else if (ilim_trip) begin
         rails_r <= 5'h00; // [R10]
         state_r <= rail_seq_pkg::ST_FLT;
      end else begin
         if (cnt_r != 24'h00_0000) cnt_r <= cnt_r - 24'h00_0001;
         case (state_r)
            rail_seq_pkg::ST_IDLE, rail_seq_pkg::ST_SHUT: if (en_s) begin
               core_r <= 1'b1; // [R6]
               step_r <= 2'd0;
               cnt_r <= 24'h00_0000;
               state_r <= rail_seq_pkg::ST_UP;
            end
            rail_seq_pkg::ST_UP: if (!en_s) begin
               cnt_r <= 24'h00_0000;
               state_r <= rail_seq_pkg::ST_DN;
            end else if (cnt_r == 24'h00_0000) begin
               rails_r <= rails_r | group_of(seq_sel, step_r); // [R1]
               cnt_r <= 24'(gap_next) * ms24; // [R2]
               step_r <= step_r + 2'd1;
               if (step_r == last) state_r <= rail_seq_pkg::ST_RUN;
            end
            rail_seq_pkg::ST_RUN: if (!en_s) begin
               step_r <= last;
               cnt_r <= 24'h00_0000;
               state_r <= rail_seq_pkg::ST_DN;
            end
            rail_seq_pkg::ST_DN: if (cnt_r == 24'h00_0000) begin
               rails_r <= rails_r & ~group_of(seq_sel, step_r); // [R1] [R3]
               cnt_r <= 24'(gap_off) * ms24; // [R3] [R4]
               step_r <= step_r - 2'd1;
               if (step_r == 2'd0) begin
                  cnt_r <= 24'(CORE_CYCLES);
                  state_r <= rail_seq_pkg::ST_CORE;
               end
            end
            rail_seq_pkg::ST_CORE: if (cnt_r == 24'h00_0000) begin
               core_r <= 1'b0; // [R6]
               state_r <= rail_seq_pkg::ST_SHUT;
            end
            rail_seq_pkg::ST_FLT: if (!en_s) begin
               cnt_r <= 24'(CORE_CYCLES);
               state_r <= rail_seq_pkg::ST_CORE;
            end
            default: state_r <= rail_seq_pkg::ST_IDLE;
         endcase
      end
   end
   assign rails = rails_r;
   assign core_regulator_en = core_r;

   // ----------------------------------------
   // temperature correction
   // ----------------------------------------
   logic [23:0] sec_r;
   logic have_r, ready_r, start_r;
   logic [8:0] corr_r, code_r;
   wire [4:0] lo5 = low_r[rail_seq_pkg::LOW_OFS +: 5];
   wire [4:0] h1 = high_r[4:0];
   wire [5:0] h12 = 6'(h1) + 6'(extra_r[4:0]);
   wire [5:0] span = 6'(h1) + 6'(lo5);
   wire [7:0] den = (hthr_r > lthr_r) ? hthr_r - lthr_r : 8'h01;
   wire [13:0] num = 14'(8'(temp_r - lthr_r)) * 14'(span);
   wire [13:0] quo = num / 14'(den);
   logic signed [11:0] ofs;
   always_comb begin
      if (temp_r <= lthr_r) ofs = -12'(lo5); // [R18] [R22]
      else if (temp_r >= hthr_r) ofs = 12'(h12); // [R19] [R22]
      else ofs = 12'(quo) - 12'(lo5); // [R22]
   end
   wire signed [11:0] sum = $signed({3'b000, base}) + ofs;
   wire [8:0] corrected = sum < 0 ? 9'h000 : (sum > 12'sd511 ? 9'h1ff : sum[8:0]); // [R22]
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         sec_r <= 24'h00_0000;
         start_r <= 1'b0;
         have_r <= 1'b0;
         ready_r <= 1'b0;
         temp_r <= 8'h00;
         corr_r <= 9'h000;
         code_r <= 9'h000;
      end else begin
         sec_r <= (!comp_en || sec_r == 24'h00_0000) ? 24'(SAMPLE_CYCLES - 1) : sec_r - 24'h00_0001;
         start_r <= comp_en && sec_r == 24'h00_0000; // [R15]
         if (comp_en && adc_done) temp_r <= adc_result; // [R14]
         if (comp_en && adc_done) have_r <= 1'b1;
         else if (!comp_en) have_r <= 1'b0;
         if (have_r) corr_r <= corrected; // [R15]
         ready_r <= comp_en && have_r; // [R16]
         code_r <= (comp_en && ready_r) ? corr_r : base; // [R8] [R16]
      end
   end
   assign vcom_code = code_r;
   assign adc_start = start_r;
   assign adc_internal_sel = cfg_r[rail_seq_pkg::CFG_INT_SENSOR]; // [R12] [R13]

   // ----------------------------------------
   // checks
   // ----------------------------------------
   a_up_order: assert property (@(posedge ref_clk) disable iff (!resetn) // [R1]
      (seq_sel == 3'h7 && $rose(rails_r.vgon)) |-> (rails_r.avdd && rails_r.navdd && !rails_r.vgoff))
      else $error("positive gate rail rose before sources");
   a_zero_gap: assert property (@(posedge ref_clk) disable iff (!resetn) // [R2]
      (state_r == rail_seq_pkg::ST_UP && en_s && !ilim_trip && cnt_r == 0 && gap_next == 2'd0)
      |=> cnt_r == 0)
      else $error("zero gap did not step at once");
   a_off_no_rise: assert property (@(posedge ref_clk) disable iff (!resetn) // [R3]
      state_r == rail_seq_pkg::ST_DN |=> (rails_r & ~$past(rails_r)) == 5'h00)
      else $error("rail rose during power-off");
   a_off_min_gap: assert property (@(posedge ref_clk) disable iff (!resetn) // [R4]
      (state_r == rail_seq_pkg::ST_DN && !ilim_trip && cnt_r == 0 && step_r != 0)
      |=> cnt_r >= 24'(MS_CYCLES))
      else $error("power-off step shorter than 1 ms");
   a_core_off: assert property (@(posedge ref_clk) disable iff (!resetn) // [R6]
      (state_r == rail_seq_pkg::ST_CORE && cnt_r == 0 && !ilim_trip) |=> ##1 !core_regulator_en)
      else $error("core regulator not switched off");
   a_nack_keep: assert property (@(posedge ref_clk) disable iff (!resetn) // [R11]
      nack_evt |=> ($stable(setpoint_r) && !ack_r))
      else $error("out-of-range setpoint accepted");
   a_dev_flag: assert property (@(posedge ref_clk) disable iff (!resetn) // [R9]
      dev_s |=> fault_r)
      else $error("deviation fault not flagged");
   a_ilim_off: assert property (@(posedge ref_clk) disable iff (!resetn) // [R10]
      ilim_trip |=> (rails_r == 5'h00 && fault_r && state_r == rail_seq_pkg::ST_FLT))
      else $error("current limit did not shut rails");
   a_temp_load: assert property (@(posedge ref_clk) disable iff (!resetn) // [R14]
      (comp_en && adc_done) |=> temp_r == $past(adc_result))
      else $error("temperature reading not captured");
   a_no_early: assert property (@(posedge ref_clk) disable iff (!resetn) // [R16]
      !have_r |=> vcom_code == $past(base))
      else $error("corrected code before first sample");
   a_first_code: assert property (@(posedge ref_clk) disable iff (!resetn) // [R16]
      (comp_en && $rose(have_r)) |=> vcom_code == $past(base))
      else $error("stale corrected code after first sample");
endmodule : rail_sequencer

// ### verilog/rail_seq_pkg.sv
package rail_seq_pkg;
   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int CLK_HZ = 10_000_000;
   localparam int GAP_UNIT_US = 1000;
   localparam int CORE_OFF_MS = 200;
   localparam int SAMPLE_PERIOD_MS = 1000;
   localparam int MS_CYC = CLK_HZ / 1_000_000 * GAP_UNIT_US;
   localparam int CORE_OFF_CYC = CORE_OFF_MS * MS_CYC;
   localparam int SAMPLE_CYC = SAMPLE_PERIOD_MS * MS_CYC;
   // ----------------------------------------
   // register offsets
   // ----------------------------------------
   localparam logic [7:0] ADDR_TEMP = 8'h01;
   localparam logic [7:0] ADDR_SETPOINT = 8'h02;
   localparam logic [7:0] ADDR_DELAY = 8'h03;
   localparam logic [7:0] ADDR_LOW_POINT = 8'h05;
   localparam logic [7:0] ADDR_HIGH_POINT = 8'h06;
   localparam logic [7:0] ADDR_EXTRA_HIGH = 8'h07;
   localparam logic [7:0] ADDR_LOW_THR = 8'h08;
   localparam logic [7:0] ADDR_HIGH_THR = 8'h09;
   localparam logic [7:0] ADDR_MIN = 8'h0a;
   localparam logic [7:0] ADDR_MAX = 8'h0b;
   localparam logic [7:0] ADDR_CONFIG = 8'h0c;
   localparam logic [7:0] ADDR_SECOND_FAULT_REG = 8'h0d;
   localparam logic [7:0] ADDR_STATUS = 8'h0e;
   localparam logic [7:0] ADDR_BURN = 8'h78;
   // ----------------------------------------
   // fields and reset values
   // ----------------------------------------
   localparam int DLY_GAP1 = 0;
   localparam int DLY_GAP2 = 2;
   localparam int DLY_GAP3 = 4;
   localparam int DLY_COMP_EN = 6;
   localparam int DLY_SP_LSB = 7;
   localparam int LOW_SEQ = 0;
   localparam int LOW_OFS = 3;
   localparam int CFG_INT_SENSOR = 0;
   localparam int CFG_TFAULT = 1;
   localparam int FLT2_VCOM = 0;
   localparam logic [7:0] RST_SETPOINT = 8'hb6;
   localparam logic [7:0] RST_LOW_POINT = 8'h02;
   localparam logic [7:0] RST_MAX = 8'hff;
   localparam logic [6:0] SLAVE_ADDR = 7'h20; // arbitrary value
   // ----------------------------------------
   // sequences: four groups of five rails, group 0 in the low bits
   // ----------------------------------------
   typedef struct packed {
      logic vcom;
      logic vgoff;
      logic vgon;
      logic navdd;
      logic avdd;
   } rail_en_type;
   localparam logic [19:0] SEQ_TABLE [8] = '{
      20'h5_2041, 20'h6_2041, 20'h5_2022, 20'h6_2022,
      20'h5_0822, 20'h4_4448, 20'h0_5103, 20'h0_6083};
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000, ST_UP = 3'b001, ST_RUN = 3'b010, ST_DN = 3'b011,
      ST_CORE = 3'b100, ST_SHUT = 3'b101, ST_FLT = 3'b110
   } seq_state_type;
   typedef enum logic [2:0] {
      PH_IDLE = 3'b000, PH_ADDR = 3'b001, PH_REG = 3'b010, PH_WR = 3'b011, PH_RD = 3'b100
   } ser_phase_type;
endpackage : rail_seq_pkg

// ### testbench/serial_host_model.sv
`timescale 1ns/1ns
module serial_host_model (
   input wire logic ref_clk,
   input wire logic sda_line,
   output logic scl,
   output logic sda_low
);
   // ------
   // two-wire host, pull-up on sda
   // ------
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   task automatic hp;
      repeat (8) @(posedge ref_clk);
   endtask : hp
   task automatic bit_io(input logic b, output logic s);
      sda_low <= ~b;
      hp();
      scl <= 1'b1;
      hp();
      s = sda_line;
      scl <= 1'b0;
      hp();
   endtask : bit_io
   task automatic byte_io(input logic [7:0] d, input logic m, output logic [7:0] q, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], s);
         q[i] = s;
      end
      bit_io(m, s);
      ack = ~s;
   endtask : byte_io
   task automatic start;
      @(posedge ref_clk);
      sda_low <= 1'b0;
      hp();
      scl <= 1'b1;
      hp();
      sda_low <= 1'b1;
      hp();
      scl <= 1'b0;
      hp();
   endtask : start
   task automatic stop;
      sda_low <= 1'b1;
      hp();
      scl <= 1'b1;
      hp();
      sda_low <= 1'b0;
      hp();
   endtask : stop
   // register write; a write to the burn address stores the settings
   task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ack);
      logic [7:0] q;
      logic k;
      start();
      byte_io({rail_seq_pkg::SLAVE_ADDR, 1'b0}, 1'b1, q, k);
      byte_io(a, 1'b1, q, k);
      byte_io(d, 1'b1, q, ack);
      stop();
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      logic k;
      start();
      byte_io({rail_seq_pkg::SLAVE_ADDR, 1'b0}, 1'b1, d, k);
      byte_io(a, 1'b1, d, k);
      start();
      byte_io({rail_seq_pkg::SLAVE_ADDR, 1'b1}, 1'b1, d, k);
      byte_io(8'hff, 1'b1, d, k);
      stop();
   endtask : rd
endmodule : serial_host_model

// ### testbench/rail_sequencer_vcom_control_tb_top.sv
`timescale 1ns/1ns
module rail_sequencer_vcom_control_tb_top;
   localparam int MS = 10;
   localparam int CORE = 50;
   localparam int SAMP = 2000;
   logic ref_clk, resetn, enable_pin, vcom_deviation, vcom_ilimit, adc_go;
   logic adc_done = 1'b0;
   logic [7:0] adc_result = 8'h00;
   logic [7:0] adc_val;
   logic sda_out, sda_oe, scl, sda_low, core_regulator_en, adc_internal_sel, adc_start, nv_burn;
   logic [8:0] vcom_code;
   logic [7:0] nv_seq_data;
   rail_seq_pkg::rail_en_type rails;
   wire sda_line = ~(sda_low | sda_oe);
   int n_mismatch = 0;
   int num_checks = 0;
   int burns = 0;
   int cyc = 0;
   rail_sequencer #(.MS_CYCLES(MS), .CORE_CYCLES(CORE), .SAMPLE_CYCLES(SAMP)) uut (
      .ref_clk(ref_clk), .resetn(resetn), .scl(scl), .sda_in(sda_line), .sda_out(sda_out),
      .sda_oe(sda_oe), .enable_pin(enable_pin), .vcom_deviation(vcom_deviation),
      .vcom_ilimit(vcom_ilimit), .rails(rails), .core_regulator_en(core_regulator_en),
      .vcom_code(vcom_code), .adc_internal_sel(adc_internal_sel), .adc_start(adc_start),
      .adc_done(adc_done), .adc_result(adc_result), .nv_burn(nv_burn), .nv_seq_data(nv_seq_data));
   serial_host_model host (.ref_clk(ref_clk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));
   // ------
   // clock, converter, monitors
   // ------
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      adc_done <= adc_start & adc_go;
      adc_result <= adc_val;
   end
   always @(negedge ref_clk) if (nv_burn === 1'b1) burns++;
   task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] s);
      num_checks++;
      if (s !== e) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic step(input logic [4:0] v, input int g);
      int n;
      logic [4:0] last;
      n = 0;
      last = rails;
      while (rails === last && n < 400) begin
         @(negedge ref_clk);
         n++;
      end
      chk("rails", {4'h0, v}, rails);
      if (g >= 0) chk("gap", 9'(g), (n > g - 3 && n < g + 3) ? 9'(g) : 9'(n));
   endtask : step
   task automatic run(input int g1, input int g2);
      @(posedge ref_clk);
      enable_pin <= 1'b1;
      step(5'h03, -1);
      step(5'h07, g1);
      step(5'h1f, g2);
      @(posedge ref_clk);
      enable_pin <= 1'b0;
      step(5'h07, -1);
      step(5'h03, g2 > MS ? g2 : MS);
      step(5'h00, g1 > MS ? g1 : MS);
      repeat (CORE - 3) @(negedge ref_clk);
      chk("core", 9'h1, core_regulator_en);
      repeat (6) @(negedge ref_clk);
      chk("core", 9'h0, core_regulator_en);
   endtask : run
   task automatic wait_start(output int t);
      t = 0;
      for (int n = 0; n < 2 * SAMP; n++) begin
         @(negedge ref_clk);
         if (adc_start === 1'b1) begin
            t = cyc;
            return;
         end
      end
   endtask : wait_start
   task automatic close_out;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : close_out
   initial begin
      repeat (60000) @(posedge ref_clk);
      n_mismatch++;
      close_out();
   end
   // ------
   // main sequence
   // ------
   initial begin
      logic ack;
      logic [7:0] d, sp;
      logic [8:0] base;
      int t0, t1;
      logic [7:0] bad [2];
      logic [15:0] cfg [6];
      resetn = 1'b0;
      bad = '{8'h0f, 8'hf1};
      cfg = '{16'h0840, 16'h0990, 16'h0527, 16'h0603, 16'h0702, 16'h0c01};
      enable_pin = 1'b0;
      vcom_deviation = 1'b0;
      vcom_ilimit = 1'b0;
      adc_go = 1'b0;
      adc_val = 8'h00;
      void'($urandom(47));
      sp = 8'h10 + 8'($urandom % 225);
      repeat (4) @(posedge ref_clk);
      resetn <= 1'b1;
      repeat (4) @(negedge ref_clk);
      chk("vcom", 9'h16c, vcom_code);
      chk("core", 9'h1, core_regulator_en);
      host.wr(8'h0a, 8'h10, ack);
      host.wr(8'h0b, 8'hf0, ack);
      host.wr(8'h02, sp, ack);
      chk("ack", 9'h1, ack);
      host.wr(8'h03, 8'h89, ack);
      base = {sp, 1'b1};
      chk("vcom", base, vcom_code);
      foreach (bad[i]) begin
         host.wr(8'h02, bad[i], ack);
         chk("nack", 9'h0, ack);
         chk("vcom", base, vcom_code);
      end
      host.wr(8'h05, 8'h07, ack);
      chk("seq", 9'h07, nv_seq_data);
      host.wr(rail_seq_pkg::ADDR_BURN, 8'h00, ack);
      chk("burn", 9'h1, 9'(burns));
      run(MS, 2 * MS);
      host.wr(8'h03, 8'h80, ack);
      run(1, 1);
      @(posedge ref_clk);
      enable_pin <= 1'b1;
      repeat (20) @(posedge ref_clk);
      vcom_deviation <= 1'b1;
      repeat (8) @(posedge ref_clk);
      vcom_deviation <= 1'b0;
      host.rd(8'h0d, d);
      chk("flag", 9'h1, 9'(d[0]));
      chk("rails", 9'h1f, rails);
      host.wr(8'h0d, 8'h01, ack);
      @(posedge ref_clk);
      vcom_ilimit <= 1'b1;
      repeat (MS + 8) @(posedge ref_clk);
      vcom_ilimit <= 1'b0;
      chk("rails", 9'h0, rails);
      host.rd(8'h0d, d);
      chk("flag", 9'h1, 9'(d[0]));
      enable_pin <= 1'b0;
      foreach (cfg[i]) host.wr(cfg[i][15:8], cfg[i][7:0], ack);
      chk("isel", 9'h1, adc_internal_sel);
      host.wr(8'h03, 8'hc0, ack);
      base = {sp, 1'b1};
      chk("vcom", base, vcom_code);
      adc_val <= 8'($urandom % 48);
      adc_go <= 1'b1;
      wait_start(t0);
      repeat (5) @(negedge ref_clk);
      chk("vcom", base - 9'h4, vcom_code);
      host.rd(8'h01, d);
      chk("temp", {1'b0, adc_val}, {1'b0, d});
      adc_val <= 8'ha0 + 8'($urandom % 64);
      wait_start(t1);
      chk("period", 9'h0, (t1 - t0 == SAMP) ? 9'h0 : 9'h1ff);
      repeat (5) @(negedge ref_clk);
      chk("vcom", base + 9'h5, vcom_code);
      adc_val <= 8'h57;
      wait_start(t1);
      repeat (5) @(negedge ref_clk);
      chk("vcom", base - 9'h2, vcom_code);
      close_out();
   end
endmodule : rail_sequencer_vcom_control_tb_top
